// >>> src/crr_pkg.sv
// Package of constants and types for the conversion result slot registers
package crr_pkg;
	localparam int unsigned ADDR_W = 8;
	localparam int unsigned DATA_W = 32;
	localparam int unsigned RES_W = 10;
	localparam int unsigned NUM_SLOTS = 4;
	// Register offsets (byte addresses)
	localparam logic [7:0] OFF_SLOT0 = 8'h00;
	localparam logic [7:0] OFF_SLOT1 = 8'h04;
	localparam logic [7:0] OFF_SLOT2 = 8'h08;
	localparam logic [7:0] OFF_SLOT3 = 8'h0c;
	localparam logic [7:0] OFF_IRQ_STATUS = 8'h10;
	localparam logic [7:0] OFF_IRQ_MASK = 8'h14;
	// Field positions inside a result register
	localparam int unsigned RES_LSB = 6;
	localparam int unsigned RES_MSB = 15;
	localparam int unsigned OVR_BIT = 1;
	localparam int unsigned RDY_BIT = 0;
	// Interrupt status layout: bits 3..0 new result, bits 7..4 overrun
	localparam int unsigned IRQ_RDY_LSB = 0;
	localparam int unsigned IRQ_OVR_LSB = 4;
	localparam int unsigned IRQ_W = 8;
	// Reset values
	localparam logic [9:0] RES_RESET = 10'h000;
	localparam logic [7:0] IRQ_MASK_RESET = 8'h00;
	localparam logic [31:0] RDATA_RESET = 32'h0000_0000;

	typedef struct packed {
		logic valid;
		logic [1:0] slot;
		logic [9:0] value;
	} crr_result_t;

	typedef struct packed {
		logic [9:0] value;
		logic overrun;
		logic present;
	} crr_slot_t;
endpackage : crr_pkg

// >>> src/crr_slot.sv
// One conversion result slot: value, result-present and overrun flags
`timescale 1ns/1ps
module crr_slot
(
	// Clock and reset
	input wire logic clk,
	input wire logic rstn,
	// Converter side
	input wire logic wr_en,
	input wire logic [9:0] wr_value,
	// Software side
	input wire logic rd_en,
	// State
	output crr_pkg::crr_slot_t state,
	output logic ovr_evt
);
	logic [9:0] value_q;
	logic present_q;
	logic overrun_q;

	assign ovr_evt = wr_en && present_q && !rd_en;

	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
			value_q <= crr_pkg::RES_RESET; // [R6]
		else if (wr_en)
			value_q <= wr_value; // [R1]
	end

	// A store in the same cycle as a read wins over the read clear
	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
			present_q <= 1'b0; // [R6]
		else if (wr_en)
			present_q <= 1'b1; // [R4] [R7]
		else if (rd_en)
			present_q <= 1'b0; // [R5]
	end

	// The value being read in the same cycle counts as read, so no overrun
	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
			overrun_q <= 1'b0;
		else if (ovr_evt)
			overrun_q <= 1'b1; // [R2] [R7]
		else if (rd_en)
			overrun_q <= 1'b0; // [R3]
	end

	assign state = '{value: value_q, overrun: overrun_q, present: present_q};
endmodule : crr_slot

// >>> src/crr_irq.sv
// Sticky interrupt status with write-one-to-clear, mask and level output
`timescale 1ns/1ps
module crr_irq
(
	// Clock and reset
	input wire logic clk,
	input wire logic rstn,
	// Events
	input wire logic [7:0] evt,
	// Software access
	input wire logic clr_en,
	input wire logic [7:0] clr_bits,
	input wire logic mask_wr,
	input wire logic [7:0] mask_wdata,
	// State
	output logic [7:0] status_q,
	output logic [7:0] mask_q,
	output logic irq_q
);
	// Set wins over a clear in the same cycle
	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
			status_q <= 8'h00;
		else
			status_q <= (status_q & ~(clr_en ? clr_bits : 8'h00)) | evt;
	end

	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
			mask_q <= crr_pkg::IRQ_MASK_RESET;
		else if (mask_wr)
			mask_q <= mask_wdata;
	end

	// One cycle behind status, registered for a clean output
	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
			irq_q <= 1'b0;
		else
			irq_q <= |(status_q & mask_q);
	end
endmodule : crr_irq

// >>> src/crr_top.sv
// Conversion result registers for slots 0 to 3 with register port
// Function
// [R1] Result in bits 15-6; others zero
// [R2] Overrun set when unread result overwritten
// [R3] Overrun reads one, cleared by read
// [R4] Result-present set on every store
// [R5] Result-present cleared when result read
// [R6] Present flag shows unread; all reset zero
// [R7] Read returns prior state; store beats clear
//
// Decided for this implementation: strobed register access and the register offsets.
`timescale 1ns/1ps
module crr_top
(
	// Clock and reset
	input wire logic clk,
	input wire logic rstn,
	// Converter result input
	input crr_pkg::crr_result_t result_in,
	// Register port
	input wire logic [7:0] reg_addr,
	input wire logic [31:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [31:0] reg_rdata_q,
	// Interrupt
	output logic irq_q
);
	crr_pkg::crr_slot_t slot_state [4];
	logic [3:0] slot_wr;
	logic [3:0] slot_rd;
	logic [3:0] ovr_evt;
	logic [7:0] irq_status;
	logic [7:0] irq_mask;
	logic [31:0] rdata_d;

	genvar g;
	generate
		for (g = 0; g < 4; g++)
		begin : gen_slot
			assign slot_wr[g] = result_in.valid && (result_in.slot == 2'(g));
			assign slot_rd[g] = reg_rd && (reg_addr == 8'(g * 4));
			crr_slot u_slot
			(
				.clk(clk),
				.rstn(rstn),
				.wr_en(slot_wr[g]),
				.wr_value(result_in.value),
				.rd_en(slot_rd[g]),
				.state(slot_state[g]),
				.ovr_evt(ovr_evt[g])
			);
		end
	endgenerate

	crr_irq u_irq
	(
		.clk(clk),
		.rstn(rstn),
		.evt({ovr_evt, slot_wr}),
		.clr_en(reg_wr && reg_addr == crr_pkg::OFF_IRQ_STATUS),
		.clr_bits(reg_wdata[7:0]),
		.mask_wr(reg_wr && reg_addr == crr_pkg::OFF_IRQ_MASK),
		.mask_wdata(reg_wdata[7:0]),
		.status_q(irq_status),
		.mask_q(irq_mask),
		.irq_q(irq_q)
	);

	function automatic logic [31:0] pack_slot(crr_pkg::crr_slot_t s);
		logic [31:0] w;
		w = 32'h0000_0000; // [R1]
		w[crr_pkg::RES_MSB:crr_pkg::RES_LSB] = s.value; // [R1]
		w[crr_pkg::OVR_BIT] = s.overrun; // [R3]
		w[crr_pkg::RDY_BIT] = s.present; // [R6]
		return w;
	endfunction : pack_slot

	// Read data sampled from pre-read state; unmapped reads return zero
	always_comb
	begin
		case (reg_addr)
			crr_pkg::OFF_SLOT0: rdata_d = pack_slot(slot_state[0]); // [R7]
			crr_pkg::OFF_SLOT1: rdata_d = pack_slot(slot_state[1]);
			crr_pkg::OFF_SLOT2: rdata_d = pack_slot(slot_state[2]);
			crr_pkg::OFF_SLOT3: rdata_d = pack_slot(slot_state[3]);
			crr_pkg::OFF_IRQ_STATUS: rdata_d = {24'h000000, irq_status};
			crr_pkg::OFF_IRQ_MASK: rdata_d = {24'h000000, irq_mask};
			default: rdata_d = crr_pkg::RDATA_RESET;
		endcase
	end

	// Data stand only in the cycle after the read strobe
	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
			reg_rdata_q <= crr_pkg::RDATA_RESET;
		else if (reg_rd)
			reg_rdata_q <= rdata_d;
		else
			reg_rdata_q <= crr_pkg::RDATA_RESET;
	end
endmodule : crr_top

// >>> verification/crr_asserts.sv
// Assertion checker for the result slot registers
`timescale 1ns/1ps
module crr_asserts
(
	// Watched ports
	input wire logic clk,
	input wire logic rstn,
	input crr_pkg::crr_result_t result_in,
	input wire logic [7:0] reg_addr,
	input wire logic [31:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire logic [31:0] reg_rdata_q,
	input wire logic irq_q
);
	default clocking @(posedge clk); endclocking
	default disable iff (!rstn);
	logic srd;
	logic nv;
	assign srd = reg_rd && reg_addr[7:4] == 4'h0 && reg_addr[1:0] == 2'h0;
	assign nv = !result_in.valid;
	sequence rd2;
		srd && nv ##1 srd && nv && reg_addr == $past(reg_addr);
	endsequence
	chk_pad_zero: assert property (
		srd |=> reg_rdata_q[31:16] == 16'h0 && reg_rdata_q[5:2] == 4'h0)
		else $error("pad set");
	chk_val_hold: assert property (
		rd2 |=> reg_rdata_q[15:6] == $past(reg_rdata_q[15:6]))
		else $error("value moved");
	chk_store_seen: assert property (
		result_in.valid ##1 srd && nv &&
		reg_addr[3:2] == $past(result_in.slot) |=>
		reg_rdata_q[15:6] == $past(result_in.value, 2) && reg_rdata_q[0])
		else $error("store lost");
	chk_ovr_set: assert property (
		result_in.valid ##1 result_in.valid && !reg_rd &&
		result_in.slot == $past(result_in.slot) ##1 srd && nv &&
		reg_addr[3:2] == $past(result_in.slot) |=> reg_rdata_q[1])
		else $error("no overrun");
	chk_clr_read: assert property (rd2 |=> reg_rdata_q[1:0] == 2'h0)
		else $error("flags kept");
	chk_store_wins: assert property (
		srd && result_in.valid && reg_addr[3:2] == result_in.slot ##1
		srd && nv && reg_addr == $past(reg_addr) |=> reg_rdata_q[1:0] == 2'h1)
		else $error("set lost");
	chk_idle_zero: assert property (!reg_rd |=> reg_rdata_q == 32'h0)
		else $error("stray data");
	cov_rd2: cover property (rd2);
	cov_ovr: cover property (srd ##1 reg_rdata_q[1]);
	cov_irq: cover property ($rose(irq_q));
endmodule : crr_asserts
bind crr_top crr_asserts crr_asserts_i (.clk(clk), .rstn(rstn),
	.result_in(result_in), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
	.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata_q(reg_rdata_q),
	.irq_q(irq_q));

// >>> verification/crr_top_tb.sv
// Random bench for the result slot registers
`timescale 1ns/1ps
module crr_top_tb;
	logic clk = 1'b0;
	logic rstn = 1'b0;
	crr_pkg::crr_result_t result_in = '0;
	logic [7:0] reg_addr = 8'h00;
	logic [31:0] reg_wdata = 32'h0;
	logic reg_wr = 1'b0;
	logic reg_rd = 1'b0;
	logic [31:0] reg_rdata_q;
	logic irq_q;
	logic [9:0] val[4] = '{default: 10'h0};
	logic [1:0] fl[4] = '{default: 2'h0};
	logic [7:0] at[6] = '{8'h00, 8'h04, 8'h08, 8'h0c, 8'h14, 8'h20};
	logic [31:0] ex = 32'h0;
	logic [7:0] mk = 8'h00;
	int fails = 0;
	int check_count = 0;
	crr_top crr_top_i (.clk(clk), .rstn(rstn), .result_in(result_in),
		.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
		.reg_rd(reg_rd), .reg_rdata_q(reg_rdata_q), .irq_q(irq_q));
	initial
	begin
		forever #5 clk = ~clk;
	end
	task chk(string n, logic [31:0] s, logic [31:0] e);
		check_count++;
		if (s !== e)
		begin
			fails++;
			$display("Error %s expected %h seen %h", n, e, s);
		end
	endtask : chk
	task end_sim;
		$display("checks %0d errors %0d", check_count, fails);
		if (fails == 0 && check_count > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask : end_sim
	// One bus cycle; checks the answer of the read issued one cycle before
	task op(bit w, bit [1:0] s, bit r, bit wr, logic [7:0] a, logic [31:0] d);
		logic [9:0] v;
		v = 10'($urandom);
		@(posedge clk);
		result_in <= '{w, s, v};
		reg_rd <= r;
		reg_wr <= wr;
		reg_addr <= a;
		reg_wdata <= d;
		#1 chk("rdata", reg_rdata_q, ex);
		ex = 32'h0;
		if (r && a < 8'h10)
		begin
			ex = {16'h0, val[a[3:2]], 4'h0, fl[a[3:2]]};
			fl[a[3:2]] = 2'h0;
		end
		if (r && a == 8'h14)
			ex = {24'h0, mk};
		if (wr && a == 8'h14)
			mk = d[7:0];
		if (w)
		begin
			fl[s] = {fl[s][1] | fl[s][0], 1'b1};
			val[s] = v;
		end
	endtask : op
	initial
	begin
		#100000;
		fails++;
		end_sim();
	end
	initial
	begin
		void'($urandom(92879));
		repeat (5) @(posedge clk);
		chk("reset", reg_rdata_q, 32'h0);
		rstn <= 1'b1;
		for (int i = 0; i < 4; i++)
			op(0, 0, 1, 0, at[i], 0);
		for (int i = 0; i < 4; i++)
		begin
			op(1, 2'(i), 0, 0, 0, 0);
			op(1, 2'(i), 0, 0, 0, 0);
			op(0, 0, 1, 0, at[i], 0);
			op(1, 2'(i), 1, 0, at[i], 0);
			op(0, 0, 1, 0, at[i], 0);
			op(0, 0, 0, 1, at[i], '1);
			op(0, 0, 1, 0, at[i], 0);
		end
		op(0, 0, 0, 1, 8'h10, 32'hff);
		op(0, 0, 0, 1, 8'h14, 32'h01);
		op(1, 1, 0, 0, 0, 0);
		repeat (3) op(0, 0, 0, 0, 0, 0);
		chk("irq", 32'(irq_q), 32'h0);
		op(1, 0, 0, 0, 0, 0);
		repeat (3) op(0, 0, 0, 0, 0, 0);
		chk("irq", 32'(irq_q), 32'h1);
		op(0, 0, 0, 1, 8'h10, 32'h01);
		repeat (3) op(0, 0, 0, 0, 0, 0);
		chk("irq", 32'(irq_q), 32'h0);
		// Only the slot 1 store is left in status after the clear
		op(0, 0, 1, 0, 8'h10, 0);
		ex = 32'h0000_0002;
		op(0, 0, 0, 0, 0, 0);
		// Mid-run reset must clear every slot, flag and the mask; the status register is not read back
		@(posedge clk);
		rstn <= 1'b0;
		repeat (2) @(posedge clk);
		chk("reset", reg_rdata_q, 32'h0);
		chk("irq", 32'(irq_q), 32'h0);
		rstn <= 1'b1;
		val = '{default: 10'h0};
		fl = '{default: 2'h0};
		mk = 8'h00;
		ex = 32'h0;
		for (int i = 0; i < 5; i++)
			op(0, 0, 1, 0, at[i], 0);
		for (int i = 0; i < 300; i++)
			op($urandom % 2, 2'($urandom), $urandom % 2, 0, at[$urandom % 6], 0);
		op(0, 0, 0, 0, 0, 0);
		end_sim();
	end
endmodule : crr_top_tb
